// >>> src/ext_irq_pkg.sv
// Shared constants and types for the external pin interrupt unit.
package ext_irq_pkg;

  // Register word offsets on the plain register port.
  localparam logic [7:0] OFF_CONTROL_SENSE = 8'h00;
  localparam logic [7:0] OFF_ENABLE_MASK = 8'h01;
  localparam logic [7:0] OFF_FLAG_BITS = 8'h02;
  localparam logic [7:0] OFF_PC_MASK = 8'h03;

  // Reset values of the registers.
  localparam logic [7:0] RST_CONTROL_SENSE = 8'h00;
  localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_FLAG_BITS = 8'h00;
  localparam logic [7:0] RST_PC_MASK = 8'h00;

  // Field positions in the control sense register.
  localparam int SENSE_B_LO_POS = 2;
  localparam int SENSE_A_LO_POS = 0;

  // Bit positions shared by the enable mask and the flag register.
  localparam int EXT_B_POS = 7;
  localparam int EXT_A_POS = 6;
  localparam int PIN_CHG_POS = 5;

  // Bits of the enable mask and flag register that exist.
  localparam logic [7:0] IRQ_BITS_USED = 8'hE0;

  // Number of pin change inputs served.
  localparam int PC_COUNT = 8;

  // Two-bit sense selection of a dedicated interrupt pin.
  typedef enum logic [1:0]
  {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } sense_e;

  // One bit for each interrupt source, used for requests and acknowledges.
  typedef struct packed
  {
    logic ext_b;
    logic ext_a;
    logic pin_chg;
  } irq_vec_s;

endpackage

// >>> src/external_pin_interrupt_unit.sv
`timescale 1ns/1ps

module external_pin_interrupt_unit
#(
  parameter int PC_WIDTH = ext_irq_pkg::PC_COUNT
)
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic [PC_WIDTH-1:0] i_pin_change_inputs,
  input wire logic i_global_irq_enable,
  input wire ext_irq_pkg::irq_vec_s i_vector_ack,
  output ext_irq_pkg::irq_vec_s o_irq_req,
  output logic o_wake
);

  // The mask register is eight bits wide, so no more pins can be served.
  if (PC_WIDTH < 1 || PC_WIDTH > 8)
  begin : g_width_check
    $error("PC_WIDTH must lie between 1 and 8");
  end

  // Decides whether a sampled edge matches the selected sense.
  function automatic logic edge_hit(input ext_irq_pkg::sense_e sense,
                                    input logic old_v,
                                    input logic new_v);
    logic hit;
    hit = 1'b0;
    case (sense)
      ext_irq_pkg::SENSE_ANY_CHANGE: hit = old_v ^ new_v;
      ext_irq_pkg::SENSE_FALLING: hit = old_v & ~new_v;
      ext_irq_pkg::SENSE_RISING: hit = ~old_v & new_v;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Synchroniser and history stages for the two dedicated pins.
  logic a_s1_q, a_s1_d;
  logic a_s2_q, a_s2_d;
  logic a_s3_q, a_s3_d;
  logic b_s1_q, b_s1_d;
  logic b_s2_q, b_s2_d;
  logic b_s3_q, b_s3_d;
  // Synchroniser and history stages for the pin change inputs.
  logic [PC_WIDTH-1:0] pc_s1_q, pc_s1_d;
  logic [PC_WIDTH-1:0] pc_s2_q, pc_s2_d;
  logic [PC_WIDTH-1:0] pc_s3_q, pc_s3_d;

  // Software visible registers.
  logic [7:0] control_sense_q, control_sense_d;
  logic [7:0] enable_mask_q, enable_mask_d;
  logic [7:0] pin_change_mask_q, pin_change_mask_d;
  // Sticky flags of the three sources.
  logic ext_flag_b_q, ext_flag_b_d;
  logic ext_flag_a_q, ext_flag_a_d;
  logic pin_change_flag_q, pin_change_flag_d;
  // Registered read data and interrupt requests.
  logic [7:0] rdata_q, rdata_d;
  ext_irq_pkg::irq_vec_s req_q, req_d;

  // Decoded fields of the registers.
  ext_irq_pkg::sense_e sense_a;
  ext_irq_pkg::sense_e sense_b;
  logic en_b, en_a, en_pc;
  logic level_a, level_b;
  // Trigger pulses from the clocked detectors.
  logic hit_a, hit_b, hit_pc;
  // Write-one-to-clear strobes for each flag.
  logic clr_b, clr_a, clr_pc;
  // Masked pin change mask, trimmed to the served width.
  logic [PC_WIDTH-1:0] pc_mask;

  // Field decode; sense fields sit at fixed positions in control_sense.
  always_comb
  begin
    sense_b = ext_irq_pkg::sense_e'(
      control_sense_q[ext_irq_pkg::SENSE_B_LO_POS +: 2]);
    sense_a = ext_irq_pkg::sense_e'(
      control_sense_q[ext_irq_pkg::SENSE_A_LO_POS +: 2]);
    en_b = enable_mask_q[ext_irq_pkg::EXT_B_POS];
    en_a = enable_mask_q[ext_irq_pkg::EXT_A_POS];
    en_pc = enable_mask_q[ext_irq_pkg::PIN_CHG_POS];
    level_a = (sense_a == ext_irq_pkg::SENSE_LOW_LEVEL);
    level_b = (sense_b == ext_irq_pkg::SENSE_LOW_LEVEL);
    pc_mask = pin_change_mask_q[PC_WIDTH-1:0];
  end

  // Next values of the synchronisers; the first stage feeds only the second.
  // The pins are sampled no matter which way the port drives them.
  always_comb
  begin
    a_s1_d = i_ext_irq_pin_a;
    a_s2_d = a_s1_q;
    a_s3_d = a_s2_q;
    b_s1_d = i_ext_irq_pin_b;
    b_s2_d = b_s1_q;
    b_s3_d = b_s2_q;
    pc_s1_d = i_pin_change_inputs;
    pc_s2_d = pc_s1_q;
    pc_s3_d = pc_s2_q;
  end

  // Synchroniser flops; the dedicated pin stages reset high like an undriven pull-up pin, the pin change stages reset low.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      a_s1_q <= 1'b1;
      a_s2_q <= 1'b1;
      a_s3_q <= 1'b1;
      b_s1_q <= 1'b1;
      b_s2_q <= 1'b1;
      b_s3_q <= 1'b1;
      pc_s1_q <= '0;
      pc_s2_q <= '0;
      pc_s3_q <= '0;
    end
    else
    begin
      a_s1_q <= a_s1_d;
      a_s2_q <= a_s2_d;
      a_s3_q <= a_s3_d;
      b_s1_q <= b_s1_d;
      b_s2_q <= b_s2_d;
      b_s3_q <= b_s3_d;
      pc_s1_q <= pc_s1_d;
      pc_s2_q <= pc_s2_d;
      pc_s3_q <= pc_s3_d;
    end
  end

  // Edge detectors compare the synchronised sample with the one before it.
  // A pulse wider than one clock period is always seen by both stages.
  always_comb
  begin
    hit_a = edge_hit(sense_a, a_s3_q, a_s2_q);
    hit_b = edge_hit(sense_b, b_s3_q, b_s2_q);
    hit_pc = |((pc_s2_q ^ pc_s3_q) & pc_mask);
  end

  // Write-one-to-clear strobes for the flag register.
  always_comb
  begin
    clr_b = 1'b0;
    clr_a = 1'b0;
    clr_pc = 1'b0;
    if (i_wr && i_addr == ext_irq_pkg::OFF_FLAG_BITS)
    begin
      clr_b = i_wdata[ext_irq_pkg::EXT_B_POS];
      clr_a = i_wdata[ext_irq_pkg::EXT_A_POS];
      clr_pc = i_wdata[ext_irq_pkg::PIN_CHG_POS];
    end
  end

  // Flag next values; a trigger in the clearing cycle wins over the clear.
  always_comb
  begin
    ext_flag_b_d = ext_flag_b_q;
    ext_flag_a_d = ext_flag_a_q;
    pin_change_flag_d = pin_change_flag_q;
    // Software write of one or the vector running both clear a flag.
    if (clr_b || i_vector_ack.ext_b)
    begin
      ext_flag_b_d = 1'b0;
    end
    if (clr_a || i_vector_ack.ext_a)
    begin
      ext_flag_a_d = 1'b0;
    end
    if (clr_pc || i_vector_ack.pin_chg)
    begin
      pin_change_flag_d = 1'b0;
    end
    // Triggers set their flag after the clears so they take priority over them.
    if (hit_b)
    begin
      ext_flag_b_d = 1'b1;
    end
    if (hit_a)
    begin
      ext_flag_a_d = 1'b1;
    end
    if (hit_pc)
    begin
      pin_change_flag_d = 1'b1;
    end
    // A level-sensed pin keeps its flag cleared.
    if (level_b)
    begin
      ext_flag_b_d = 1'b0;
    end
    if (level_a)
    begin
      ext_flag_a_d = 1'b0;
    end
  end

  // Register writes; only existing bits of the enable mask are stored.
  always_comb
  begin
    control_sense_d = control_sense_q;
    enable_mask_d = enable_mask_q;
    pin_change_mask_d = pin_change_mask_q;
    if (i_wr)
    begin
      case (i_addr)
        ext_irq_pkg::OFF_CONTROL_SENSE: control_sense_d = i_wdata;
        ext_irq_pkg::OFF_ENABLE_MASK:
          enable_mask_d = i_wdata & ext_irq_pkg::IRQ_BITS_USED;
        ext_irq_pkg::OFF_PC_MASK: pin_change_mask_d = i_wdata;
        default: control_sense_d = control_sense_q;
      endcase
    end
  end

  // Read data for the cycle after the read strobe; unmapped reads give zero.
  always_comb
  begin
    rdata_d = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        ext_irq_pkg::OFF_CONTROL_SENSE: rdata_d = control_sense_q;
        ext_irq_pkg::OFF_ENABLE_MASK: rdata_d = enable_mask_q;
        ext_irq_pkg::OFF_FLAG_BITS:
        begin
          rdata_d[ext_irq_pkg::EXT_B_POS] = ext_flag_b_q;
          rdata_d[ext_irq_pkg::EXT_A_POS] = ext_flag_a_q;
          rdata_d[ext_irq_pkg::PIN_CHG_POS] = pin_change_flag_q;
        end
        ext_irq_pkg::OFF_PC_MASK: rdata_d = pin_change_mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Requests to the core: source enable and global enable gate each one.
  // A level-sensed pin requests for as long as its sample stays low.
  always_comb
  begin
    req_d.ext_b = i_global_irq_enable & en_b &
      (level_b ? ~b_s2_q : ext_flag_b_q);
    req_d.ext_a = i_global_irq_enable & en_a &
      (level_a ? ~a_s2_q : ext_flag_a_q);
    req_d.pin_chg = i_global_irq_enable & en_pc & pin_change_flag_q;
  end

  // Register state, flags, read data and requests.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      control_sense_q <= ext_irq_pkg::RST_CONTROL_SENSE;
      enable_mask_q <= ext_irq_pkg::RST_ENABLE_MASK;
      pin_change_mask_q <= ext_irq_pkg::RST_PC_MASK;
      ext_flag_b_q <= ext_irq_pkg::RST_FLAG_BITS[ext_irq_pkg::EXT_B_POS];
      ext_flag_a_q <= ext_irq_pkg::RST_FLAG_BITS[ext_irq_pkg::EXT_A_POS];
      pin_change_flag_q <=
        ext_irq_pkg::RST_FLAG_BITS[ext_irq_pkg::PIN_CHG_POS];
      rdata_q <= 8'h00;
      req_q <= '0;
    end
    else
    begin
      control_sense_q <= control_sense_d;
      enable_mask_q <= enable_mask_d;
      pin_change_mask_q <= pin_change_mask_d;
      ext_flag_b_q <= ext_flag_b_d;
      ext_flag_a_q <= ext_flag_a_d;
      pin_change_flag_q <= pin_change_flag_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
    end
  end

  // Wake path: deliberately clockless so it works with the clock stopped.
  // It reads the raw pins; a low level or a masked pin differing from the
  // last clocked sample raises it. Glitches here only wake the part.
  always_comb
  begin
    o_wake = (en_a & level_a & ~i_ext_irq_pin_a) |
      (en_b & level_b & ~i_ext_irq_pin_b) |
      (en_pc & |((i_pin_change_inputs ^ pc_s3_q) & pc_mask));
  end

  // Read data and request outputs come straight from flops.
  assign o_rdata = rdata_q;
  assign o_irq_req = req_q;

  // Checks on the unit's own behaviour.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_level_req_b: assert property (
    level_b && en_b && i_global_irq_enable && !b_s2_q |=> o_irq_req.ext_b)
    else $error("level request on pin b missing");

  a_level_flag_zero: assert property (
    level_a && $past(level_a) |-> !ext_flag_a_q)
    else $error("flag a set while level sensed");

  a_edge_flag_b: assert property (
    sense_b == ext_irq_pkg::SENSE_RISING && b_s2_q && !b_s3_q
    |=> ext_flag_b_q)
    else $error("rising edge on pin b not flagged");

  a_edge_flag_a: assert property (
    sense_a == ext_irq_pkg::SENSE_FALLING && !a_s2_q && a_s3_q
    |=> ext_flag_a_q)
    else $error("falling edge on pin a not flagged");

  a_fall_ignores_rise: assert property (
    sense_a == ext_irq_pkg::SENSE_FALLING && a_s2_q && !a_s3_q &&
    !ext_flag_a_q |=> !ext_flag_a_q)
    else $error("rising edge flagged in falling sense");

  a_pin_sync_delay: assert property (
    $rose(a_s1_q) |=> a_s2_q ##1 a_s3_q)
    else $error("pin a synchroniser delay wrong");

  a_pc_toggle_flag: assert property (
    |((pc_s2_q ^ $past(pc_s2_q)) & pc_mask) && $stable(pin_change_mask_q)
    |=> pin_change_flag_q)
    else $error("masked pin toggle not flagged");

  a_pc_mask_off: assert property (
    pc_mask == '0 && !pin_change_flag_q |=> !pin_change_flag_q)
    else $error("unmasked pin change flagged");

  a_pc_w1c_clear: assert property (
    clr_pc && !hit_pc |=> !pin_change_flag_q ##1 o_irq_req.pin_chg == 1'b0)
    else $error("pin change flag clear failed");

  a_gate_pc_req: assert property (
    o_irq_req.pin_chg |-> $past(i_global_irq_enable && en_pc &&
    pin_change_flag_q))
    else $error("pin change request not gated");

  a_gate_edge_a: assert property (
    o_irq_req.ext_a && !$past(level_a) |-> $past(en_a) && $past(ext_flag_a_q))
    else $error("pin a request not gated");

  a_gate_edge_b: assert property (
    !i_global_irq_enable || !en_b |=> !o_irq_req.ext_b)
    else $error("pin b request while disabled");

  a_set_beats_clear: assert property (
    hit_a && (clr_a || i_vector_ack.ext_a) && !level_a |=> ext_flag_a_q)
    else $error("trigger lost against clear");

  c_level_request: cover property (level_b && o_irq_req.ext_b);
  c_pin_change_irq: cover property (hit_pc ##[1:3] o_irq_req.pin_chg);
  c_edge_then_ack: cover property (
    ext_flag_a_q ##1 i_vector_ack.ext_a ##1 !ext_flag_a_q);
  c_any_change_b: cover property (
    sense_b == ext_irq_pkg::SENSE_ANY_CHANGE && hit_b);

endmodule

// >>> verif/irq_partner_model.sv
`timescale 1ns/1ps

// Far-side model: pin sources, the global enable and the CPU vector acks.
module irq_partner_model
(
  input wire logic i_core_clk,
  input wire ext_irq_pkg::irq_vec_s i_irq_req,
  output logic o_pin_a,
  output logic o_pin_b,
  output logic [7:0] o_pins,
  output logic o_gie,
  output ext_irq_pkg::irq_vec_s o_ack
);
  // Acks are sent only while this is set.
  logic ack_en;
  // Cycles a request waits before the vector runs.
  int ack_delay;
  // Cycles counted while a request waits.
  int wait_cnt;
  // Quiet time after an ack while the request drains.
  int holdoff;

  // Pins idle high, pin change inputs low, no acks at start.
  initial
  begin
    o_pin_a = 1'b1;
    o_pin_b = 1'b1;
    o_pins = 8'h00;
    o_gie = 1'b0;
    o_ack = '0;
    ack_en = 1'b0;
    ack_delay = 2;
    wait_cnt = 0;
    holdoff = 0;
  end

  // Levels change just after an edge and are held for whole cycles.
  // A low level stays until the bench lifts it, well past any start-up.
  task automatic drive(input logic a, input logic b, input logic [7:0] p);
    @(posedge i_core_clk);
    o_pin_a <= a;
    o_pin_b <= b;
    o_pins <= p;
  endtask

  // Runs the vector of each pending source after the delay.
  always @(posedge i_core_clk)
  begin
    if (holdoff > 0)
    begin
      o_ack <= '0;
      holdoff <= holdoff - 1;
    end
    else if (ack_en && (i_irq_req != '0))
    begin
      if (wait_cnt >= ack_delay)
      begin
        o_ack <= i_irq_req;
        wait_cnt <= 0;
        holdoff <= 4;
      end
      else
      begin
        o_ack <= '0;
        wait_cnt <= wait_cnt + 1;
      end
    end
    else
    begin
      o_ack <= '0;
      wait_cnt <= 0;
    end
  end
endmodule

// >>> verif/external_pin_interrupt_unit_tb_top.sv
`timescale 1ns/1ps

// Self-checking bench for the external pin interrupt unit.
module external_pin_interrupt_unit_tb_top;
  logic clk;
  logic i_reset;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [7:0] rdata;
  logic pin_a;
  logic pin_b;
  logic [7:0] pins;
  logic gie;
  ext_irq_pkg::irq_vec_s ack;
  ext_irq_pkg::irq_vec_s req;
  logic wake;
  int errors = 0;
  int num_checks = 0;
  localparam logic [7:0] CTL = ext_irq_pkg::OFF_CONTROL_SENSE;
  localparam logic [7:0] ENA = ext_irq_pkg::OFF_ENABLE_MASK;
  localparam logic [7:0] FLG = ext_irq_pkg::OFF_FLAG_BITS;
  localparam logic [7:0] PCM = ext_irq_pkg::OFF_PC_MASK;

  external_pin_interrupt_unit dut
  (
    .i_core_clk(clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_irq_pin_a(pin_a),
    .i_ext_irq_pin_b(pin_b), .i_pin_change_inputs(pins),
    .i_global_irq_enable(gie), .i_vector_ack(ack), .o_irq_req(req),
    .o_wake(wake)
  );

  irq_partner_model partner
  (
    .i_core_clk(clk), .i_irq_req(req), .o_pin_a(pin_a), .o_pin_b(pin_b),
    .o_pins(pins), .o_gie(gie), .o_ack(ack)
  );

  // The clock toggles every half period of 25 ns.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // Waits a number of clock edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // One-cycle read; the data are taken in the single cycle they stand.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Compares the request vector with the expected source bits.
  task automatic req_chk(input logic [2:0] exp);
    #1;
    chk({5'h00, req}, {5'h00, exp});
  endtask

  // Reset values, read-only enable bits and an unmapped offset.
  task automatic test_regs();
    rd_chk(CTL, ext_irq_pkg::RST_CONTROL_SENSE);
    rd_chk(ENA, ext_irq_pkg::RST_ENABLE_MASK);
    rd_chk(FLG, ext_irq_pkg::RST_FLAG_BITS);
    rd_chk(PCM, ext_irq_pkg::RST_PC_MASK);
    wr(8'h04, 8'hFF);
    rd_chk(8'h04, 8'h00);
    wr(ENA, 8'hFF);
    rd_chk(ENA, 8'hE0);
    wr(PCM, 8'hA5);
    rd_chk(PCM, 8'hA5);
    wr(CTL, 8'h5A);
    rd_chk(CTL, 8'h5A);
    wr(ENA, 8'h00);
    wr(PCM, 8'h00);
  endtask

  // Falling edge on pin a, then the vector clears the flag.
  task automatic test_pin_a_fall();
    wr(CTL, 8'h02);
    wr(ENA, 8'h40);
    @(posedge clk);
    partner.o_gie <= 1'b1;
    partner.drive(1'b0, 1'b1, 8'h00);
    cyc(1);
    // The clear lands in the very cycle of the edge; the set must win.
    wr(FLG, 8'h40);
    cyc(3);
    req_chk(3'b010);
    rd_chk(FLG, 8'h40);
    @(posedge clk);
    partner.ack_en <= 1'b1;
    cyc(10);
    req_chk(3'b000);
    rd_chk(FLG, 8'h00);
    @(posedge clk);
    partner.ack_en <= 1'b0;
    partner.drive(1'b1, 1'b1, 8'h00);
    cyc(6);
    rd_chk(FLG, 8'h00);
  endtask

  // Every edge sense code of pin b, cleared by writing ones.
  task automatic test_pin_b_modes();
    logic [7:0] e;
    wr(ENA, 8'h80);
    for (int m = 1; m <= 3; m++)
    begin
      wr(CTL, 8'(m << 2));
      partner.drive(1'b1, 1'b0, 8'h00);
      cyc(6);
      e = (m != 3) ? 8'h80 : 8'h00;
      req_chk({e[7], 2'b00});
      rd_chk(FLG, e);
      wr(FLG, 8'h80);
      rd_chk(FLG, 8'h00);
      partner.drive(1'b1, 1'b1, 8'h00);
      cyc(6);
      e = (m != 2) ? 8'h80 : 8'h00;
      rd_chk(FLG, e);
      wr(FLG, 8'h80);
    end
  endtask

  // Low level on pins a and b keeps requesting while their flags read clear.
  task automatic test_low_level();
    wr(CTL, 8'h00);
    wr(ENA, 8'hC0);
    partner.drive(1'b0, 1'b0, 8'h00);
    #1;
    chk({7'h00, wake}, 8'h01);
    cyc(4);
    req_chk(3'b110);
    rd_chk(FLG, 8'h00);
    cyc(10);
    req_chk(3'b110);
    @(posedge clk);
    partner.o_gie <= 1'b0;
    cyc(3);
    req_chk(3'b000);
    @(posedge clk);
    partner.o_gie <= 1'b1;
    partner.drive(1'b1, 1'b1, 8'h00);
    cyc(4);
    req_chk(3'b000);
    chk({7'h00, wake}, 8'h00);
  endtask

  // An unmasked pin change rising, then a masked pin toggling in both directions.
  task automatic test_pin_change();
    wr(ENA, 8'h20);
    wr(PCM, 8'h08);
    @(posedge clk);
    partner.o_gie <= 1'b0;
    partner.drive(1'b1, 1'b1, 8'h10);
    cyc(6);
    rd_chk(FLG, 8'h00);
    partner.drive(1'b1, 1'b1, 8'h18);
    #1;
    chk({7'h00, wake}, 8'h01);
    cyc(6);
    req_chk(3'b000);
    rd_chk(FLG, 8'h20);
    @(posedge clk);
    partner.o_gie <= 1'b1;
    cyc(3);
    req_chk(3'b001);
    wr(FLG, 8'h20);
    cyc(2);
    req_chk(3'b000);
    rd_chk(FLG, 8'h00);
    partner.drive(1'b1, 1'b1, 8'h10);
    cyc(6);
    rd_chk(FLG, 8'h20);
  endtask

  // Reset, then the scenarios in turn.
  initial
  begin
    i_reset = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (10) @(posedge clk);
    i_reset <= 1'b0;
    test_regs();
    test_pin_a_fall();
    test_pin_b_modes();
    test_low_level();
    test_pin_change();
    give_verdict();
  end

  // The scenarios need some 230 cycles; a hang is cut at 4000.
  initial
  begin
    #(25 * 4000);
    errors++;
    give_verdict();
  end
endmodule
